/* shared/eee_lpi_pkg.sv */
// Shared constants for the EEE low-power-idle policy block.
package eee_lpi_pkg;

    // Register byte offsets (8-bit register file, byte addressed).
    localparam logic [8:0]  NP_CTRL_ADDR       = 9'h0f3;
    localparam logic [8:0]  WAIT_TIME_LO_ADDR  = 9'h0f4;
    localparam logic [8:0]  WAIT_TIME_HI_ADDR  = 9'h0f5;
    localparam logic [8:0]  LOAD_THRESH_ADDR   = 9'h0f6;
    localparam logic [8:0]  LOAD_THRESH_HI_ADDR = 9'h0f7;
    localparam logic [8:0]  RECOVERY_ADDR      = 9'h0f2;
    localparam logic [8:0]  EEE_CTRL_ADDR      = 9'h0f8;
    localparam logic [8:0]  LPI_STATUS_ADDR    = 9'h0f9;

    // Field positions.
    localparam int NP_EN_P1_BIT  = 0;
    localparam int NP_EN_P2_BIT  = 1;
    localparam int EEE_TX_EN_BIT = 0;

    // Reset values.
    localparam logic [7:0]  NP_CTRL_RST       = 8'h03;
    localparam logic [15:0] WAIT_TIME_RST     = 16'h03e8;
    localparam logic [7:0]  LOAD_THRESH_RST   = 8'h40;
    localparam logic [7:0]  LOAD_THRESH_HI_RO = 8'h01;
    localparam logic [7:0]  RECOVERY_RST      = 8'h27;
    localparam logic [7:0]  EEE_CTRL_RST      = 8'h01;

    // Timing.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int WAIT_UNIT_NS    = 1300000;
    localparam int RECOVERY_UNIT_NS = 640;
    localparam int WAIT_UNIT_CYC   = WAIT_UNIT_NS / CLK_PERIOD_NS;
    localparam int RECOVERY_UNIT_CYC = RECOVERY_UNIT_NS / CLK_PERIOD_NS;

    // One threshold count is 128 bytes of buffer use.
    localparam int LOAD_UNIT_SHIFT = 7;

    typedef enum logic [1:0] {
        ST_ACTIVE  = 2'b00,
        ST_LPI     = 2'b01,
        ST_RECOVER = 2'b10
    } lpi_state_t;

endpackage

/* core/unit_tick.sv */
// Free-running divider giving a one-cycle enable every PERIOD cycles.
`timescale 1ns/1ps
module unit_tick
    import eee_lpi_pkg::*;
#(
    parameter int PERIOD = 130000
) (
    // Clock and reset.
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // Tick output.
    output logic      o_tick
);
    localparam int CW = $clog2(PERIOD + 1);

    initial begin
        if (PERIOD < 1) begin
            $error("unit_tick: PERIOD must be at least 1");
        end
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 1'b1;
        if (cnt_r == CW'(PERIOD - 1)) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule

/* core/port_lpi_fsm.sv */
// Per-port LPI entry, exit and recovery sequencer.
`timescale 1ns/1ps
module port_lpi_fsm
    import eee_lpi_pkg::*;
#(
    parameter int OCC_W = 16
) (
    // Clock and reset.
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // Time bases.
    input  wire logic             i_wait_tick,
    input  wire logic             i_rec_tick,
    // Configuration.
    input  wire logic             i_eee_en,
    input  wire logic [15:0]      i_wait_time,
    input  wire logic [7:0]       i_recovery,
    // Queue state.
    input  wire logic             i_txq_empty,
    input  wire logic             i_txq_push,
    input  wire logic             i_force_exit,
    // Results.
    output logic                  o_lpi_req,
    output logic                  o_tx_hold
);
    lpi_state_t  st_r;
    lpi_state_t  st_nxt;
    logic [15:0] wait_cnt_r;
    logic [15:0] wait_cnt_nxt;
    logic [7:0]  rec_cnt_r;
    logic [7:0]  rec_cnt_nxt;

    always_comb begin
        st_nxt       = st_r;
        wait_cnt_nxt = wait_cnt_r;
        rec_cnt_nxt  = rec_cnt_r;
        case (st_r)
            ST_ACTIVE: begin
                if (!i_eee_en || !i_txq_empty || i_txq_push) begin
                    wait_cnt_nxt = '0;
                end else if (i_wait_tick) begin
                    if (wait_cnt_r >= i_wait_time && !i_force_exit) begin
                        st_nxt = ST_LPI;
                    end else if (wait_cnt_r != 16'hffff) begin
                        wait_cnt_nxt = wait_cnt_r + 16'h0001;
                    end
                end
            end
            ST_LPI: begin
                if (!i_eee_en || !i_txq_empty || i_txq_push ||
                    i_force_exit) begin
                    st_nxt       = ST_RECOVER;
                    rec_cnt_nxt  = '0;
                    wait_cnt_nxt = '0;
                end
            end
            ST_RECOVER: begin
                if (i_rec_tick) begin
                    if (rec_cnt_r >= i_recovery) begin
                        st_nxt = ST_ACTIVE;
                    end else begin
                        rec_cnt_nxt = rec_cnt_r + 8'h01;
                    end
                end
            end
            default: st_nxt = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r       <= ST_ACTIVE;
            wait_cnt_r <= '0;
            rec_cnt_r  <= '0;
            o_lpi_req  <= 1'b0;
            o_tx_hold  <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            wait_cnt_r <= wait_cnt_nxt;
            rec_cnt_r  <= rec_cnt_nxt;
            o_lpi_req  <= (st_nxt == ST_LPI);
            o_tx_hold  <= (st_nxt == ST_RECOVER);
        end
    end
endmodule

/* core/eee_lpi_entry_exit_control.sv */
// Top of the EEE low-power-idle policy block with its register file.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module eee_lpi_entry_exit_control
    import eee_lpi_pkg::*;
#(
    parameter int NPORTS = 3,
    parameter int OCC_W  = 16,
    parameter int WAIT_CYC = WAIT_UNIT_CYC,
    parameter int REC_CYC  = RECOVERY_UNIT_CYC
) (
    // Clock and reset.
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // Register port.
    input  wire logic [8:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    // Per-port queue state from the switch core.
    input  wire logic [NPORTS-1:0] i_txq_empty,
    input  wire logic [NPORTS-1:0] i_txq_push,
    input  wire logic [NPORTS*OCC_W-1:0] i_buf_used,
    // Outputs toward MACs and PHYs.
    output logic      [NPORTS-1:0] o_lpi_req,
    output logic      [NPORTS-1:0] o_tx_hold,
    output logic      [1:0]        o_np_enable,
    output logic                   o_lpi_exit_all
);
    initial begin
        // The status register packs the port requests into seven bits.
        if (NPORTS < 1 || NPORTS > 7 || OCC_W < 16) begin
            $error("eee_lpi_entry_exit_control: unsupported parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0]  np_ctrl_r;
    logic [7:0]  np_ctrl_nxt;
    logic [15:0] wait_time_r;
    logic [15:0] wait_time_nxt;
    logic [7:0]  thresh_r;
    logic [7:0]  thresh_nxt;
    logic [7:0]  recovery_r;
    logic [7:0]  recovery_nxt;
    logic [7:0]  eee_ctrl_r;
    logic [7:0]  eee_ctrl_nxt;
    logic [7:0]  rdata_nxt;

    logic [NPORTS-1:0] lpi_req_w;
    logic [NPORTS-1:0] tx_hold_w;
    logic              over_r;
    logic              over_nxt;

    always_comb begin
        np_ctrl_nxt   = np_ctrl_r;
        wait_time_nxt = wait_time_r;
        thresh_nxt    = thresh_r;
        recovery_nxt  = recovery_r;
        eee_ctrl_nxt  = eee_ctrl_r;
        if (i_wr) begin
            if (i_addr == NP_CTRL_ADDR) begin
                // Bits 5..2 are read-only zero; 7 and 6 are plain storage.
                np_ctrl_nxt = i_wdata & 8'hc3;
            end else if (i_addr == WAIT_TIME_LO_ADDR) begin
                wait_time_nxt[7:0] = i_wdata;
            end else if (i_addr == WAIT_TIME_HI_ADDR) begin
                wait_time_nxt[15:8] = i_wdata;
            end else if (i_addr == LOAD_THRESH_ADDR) begin
                thresh_nxt = i_wdata;
            end else if (i_addr == RECOVERY_ADDR) begin
                recovery_nxt = i_wdata;
            end else if (i_addr == EEE_CTRL_ADDR) begin
                eee_ctrl_nxt = i_wdata & 8'h01;
            end
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            if (i_addr == NP_CTRL_ADDR) begin
                rdata_nxt = np_ctrl_r;
            end else if (i_addr == WAIT_TIME_LO_ADDR) begin
                rdata_nxt = wait_time_r[7:0];
            end else if (i_addr == WAIT_TIME_HI_ADDR) begin
                rdata_nxt = wait_time_r[15:8];
            end else if (i_addr == LOAD_THRESH_ADDR) begin
                rdata_nxt = thresh_r;
            end else if (i_addr == LOAD_THRESH_HI_ADDR) begin
                rdata_nxt = LOAD_THRESH_HI_RO;
            end else if (i_addr == RECOVERY_ADDR) begin
                rdata_nxt = recovery_r;
            end else if (i_addr == EEE_CTRL_ADDR) begin
                rdata_nxt = eee_ctrl_r;
            end else if (i_addr == LPI_STATUS_ADDR) begin
                rdata_nxt = {over_r, 7'(lpi_req_w)};
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            np_ctrl_r   <= NP_CTRL_RST;
            wait_time_r <= WAIT_TIME_RST;
            thresh_r    <= LOAD_THRESH_RST;
            recovery_r  <= RECOVERY_RST;
            eee_ctrl_r  <= EEE_CTRL_RST;
            o_rdata     <= 8'h00;
        end else begin
            np_ctrl_r   <= np_ctrl_nxt;
            wait_time_r <= wait_time_nxt;
            thresh_r    <= thresh_nxt;
            recovery_r  <= recovery_nxt;
            eee_ctrl_r  <= eee_ctrl_nxt;
            o_rdata     <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer load check shared by all ports.

    // The threshold is widened to bytes so occupancy compares directly.
    always_comb begin
        over_nxt = 1'b0;
        for (int p = 0; p < NPORTS; p++) begin
            if (i_buf_used[p*OCC_W +: OCC_W] >
                (OCC_W'(thresh_r) << LOAD_UNIT_SHIFT)) begin
                over_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            over_r <= 1'b0;
        end else begin
            over_r <= over_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time bases and per-port sequencers.

    logic wait_tick;
    logic rec_tick;

    unit_tick #(.PERIOD(WAIT_CYC)) u_wait_tick (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .o_tick (wait_tick)
    );

    unit_tick #(.PERIOD(REC_CYC)) u_rec_tick (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .o_tick (rec_tick)
    );

    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : g_port
            port_lpi_fsm #(.OCC_W(OCC_W)) u_fsm (
                .i_mclk       (i_mclk),
                .i_rst        (i_rst),
                .i_wait_tick  (wait_tick),
                .i_rec_tick   (rec_tick),
                .i_eee_en     (eee_ctrl_r[EEE_TX_EN_BIT]),
                .i_wait_time  (wait_time_r),
                .i_recovery   (recovery_r),
                .i_txq_empty  (i_txq_empty[gp]),
                .i_txq_push   (i_txq_push[gp]),
                .i_force_exit (over_r),
                .o_lpi_req    (lpi_req_w[gp]),
                .o_tx_hold    (tx_hold_w[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    logic [NPORTS-1:0] lpi_req_nxt;
    logic [NPORTS-1:0] tx_hold_nxt;
    logic [1:0]        np_en_nxt;
    logic              exit_all_nxt;

    // A cleared enable is only seen at the next negotiation; the PHY
    // keeps its current EEE state until auto-negotiation is restarted.
    always_comb begin
        lpi_req_nxt  = lpi_req_w;
        tx_hold_nxt  = tx_hold_w;
        np_en_nxt    = {np_ctrl_r[NP_EN_P2_BIT],
                        np_ctrl_r[NP_EN_P1_BIT]};
        exit_all_nxt = over_r;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_lpi_req      <= '0;
            o_tx_hold      <= '0;
            o_np_enable    <= 2'b11;
            o_lpi_exit_all <= 1'b0;
        end else begin
            o_lpi_req      <= lpi_req_nxt;
            o_tx_hold      <= tx_hold_nxt;
            o_np_enable    <= np_en_nxt;
            o_lpi_exit_all <= exit_all_nxt;
        end
    end
endmodule

/* verification/eee_lpi_props.sv */
// Checker for the EEE low-power-idle policy block.
`timescale 1ns/1ps
module eee_lpi_props
    import eee_lpi_pkg::*;
#(
    parameter int NPORTS   = 3,
    parameter int OCC_W    = 16,
    parameter int WAIT_CYC = WAIT_UNIT_CYC,
    parameter int REC_CYC  = RECOVERY_UNIT_CYC
) (
    input wire logic                    i_mclk,
    input wire logic                    i_rst,
    input wire logic [8:0]              i_addr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [7:0]              o_rdata,
    input wire logic [NPORTS-1:0]       i_txq_empty,
    input wire logic [NPORTS-1:0]       i_txq_push,
    input wire logic [NPORTS*OCC_W-1:0] i_buf_used,
    input wire logic [NPORTS-1:0]       o_lpi_req,
    input wire logic [NPORTS-1:0]       o_tx_hold,
    input wire logic [1:0]              o_np_enable,
    input wire logic                    o_lpi_exit_all
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic [15:0] wt_r;
    logic [7:0]  thr_r;
    logic [7:0]  rec_r;
    logic        eee_r;
    logic        over;
    int          ecnt_r;
    int          hcnt_r;
    int          up_r;
    ////////////////////////////////////////////////////////////////////////
    // Shadow settings, so that outputs can be predicted from the inputs.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wt_r   <= 16'h03e8;
            thr_r  <= 8'h40;
            rec_r  <= 8'h27;
            eee_r  <= 1'b1;
            ecnt_r <= 0;
            hcnt_r <= 0;
            up_r   <= 0;
        end else begin
            if (i_wr && i_addr == WAIT_TIME_LO_ADDR) wt_r[7:0] <= i_wdata;
            if (i_wr && i_addr == WAIT_TIME_HI_ADDR) wt_r[15:8] <= i_wdata;
            if (i_wr && i_addr == LOAD_THRESH_ADDR) thr_r <= i_wdata;
            if (i_wr && i_addr == RECOVERY_ADDR) rec_r <= i_wdata;
            if (i_wr && i_addr == EEE_CTRL_ADDR) eee_r <= i_wdata[0];
            ecnt_r <= (i_txq_empty[0] && !i_txq_push[0]) ? ecnt_r + 1 : 0;
            hcnt_r <= o_tx_hold[0] ? hcnt_r + 1 : 0;
            up_r   <= (up_r < 3) ? up_r + 1 : up_r;
        end
    end
    always_comb begin
        over = 1'b0;
        for (int p = 0; p < NPORTS; p++)
            over |= i_buf_used[p*OCC_W +: OCC_W] >
                    (OCC_W'(thr_r) << LOAD_UNIT_SHIFT);
    end
    ////////////////////////////////////////////////////////////////////////
    np_follow_a: assert property (
        i_wr && i_addr == NP_CTRL_ADDR |->
        ##2 o_np_enable == $past(i_wdata[1:0], 2))
        else $error("next-page enables do not follow the write");
    exit_track_a: assert property (
        up_r == 3 |-> o_lpi_exit_all == $past(over, 2))
        else $error("exit-all flag does not match buffer load");
    exit_blocks_a: assert property (
        o_lpi_exit_all [*3] |-> o_lpi_req == '0)
        else $error("port in low power while load is over threshold");
    eee_gate_a: assert property (
        (!eee_r) [*3] |-> o_lpi_req == '0)
        else $error("low power requested with EEE disabled");
    wait_min_a: assert property (
        $rose(o_lpi_req[0]) |-> $past(ecnt_r) >= wt_r * WAIT_CYC)
        else $error("low power requested before the wait time");
    hold_start_a: assert property (
        $fell(o_lpi_req[0]) |-> ##[0:1] o_tx_hold[0])
        else $error("no transmit hold after leaving low power");
    hold_len_a: assert property (
        $fell(o_tx_hold[0]) |-> $past(hcnt_r) + REC_CYC >= rec_r * REC_CYC
        && $past(hcnt_r) <= (rec_r + 2) * REC_CYC)
        else $error("transmit hold length off the recovery time");
    hold_excl_a: assert property ((o_lpi_req & o_tx_hold) == '0)
        else $error("hold and low power at once");
    cover property ($rose(o_lpi_req[0]));
    cover property ($rose(o_lpi_exit_all));
    cover property ($fell(o_tx_hold[0]));
endmodule
bind eee_lpi_entry_exit_control eee_lpi_props #(
    .NPORTS(NPORTS), .OCC_W(OCC_W), .WAIT_CYC(WAIT_CYC), .REC_CYC(REC_CYC)
) props (.*);

/* verification/queue_side_model.sv */
// Queue-side model: frames arrive on command and drain while the MAC sends.
`timescale 1ns/1ps
module queue_side_model (
    // Clock and reset.
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Commands from the bench.
    input  wire logic [2:0]  i_add,
    input  wire logic [15:0] i_bytes,
    // Block outputs.
    input  wire logic [2:0]  i_lpi_req,
    input  wire logic [2:0]  i_tx_hold,
    // Queue state toward the block.
    output logic      [2:0]  o_txq_empty,
    output logic      [2:0]  o_txq_push,
    output logic      [47:0] o_buf_used
);
    logic [15:0] used_r [3];
    // One byte a cycle keeps the queue loaded long enough to be seen.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        for (int p = 0; p < 3; p++) begin
            if (i_rst)
                used_r[p] <= 16'h0000;
            else if (i_add[p])
                used_r[p] <= used_r[p] + i_bytes;
            else if (!i_lpi_req[p] && !i_tx_hold[p] && used_r[p] != 0)
                used_r[p] <= used_r[p] - 16'h0001;
        end
    end
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            o_txq_empty[p] = (used_r[p] == 16'h0000);
            o_buf_used[p*16 +: 16] = used_r[p];
        end
    end
    assign o_txq_push = i_add;
endmodule

/* verification/eee_lpi_entry_exit_control_bench.sv */
// Self-checking bench for the EEE low-power-idle policy block.
`timescale 1ns/1ps
module eee_lpi_entry_exit_control_bench
    import eee_lpi_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [8:0]  i_addr = 9'h000;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  o_rdata;
    logic [2:0]  add = 3'b000;
    logic [15:0] bytes = 16'h0000;
    logic [2:0]  txq_empty, txq_push, lpi_req, tx_hold;
    logic [47:0] buf_used;
    logic [1:0]  np_enable;
    logic        exit_all;
    logic [7:0]  expq [$];
    logic [7:0]  r;
    logic        rd_seen = 1'b0;
    int          errors = 0;
    int          n_compared = 0;
    int          seed = 32'h8811d26b;
    localparam logic [8:0] RA [8] = '{RECOVERY_ADDR, NP_CTRL_ADDR,
        WAIT_TIME_LO_ADDR, WAIT_TIME_HI_ADDR, LOAD_THRESH_ADDR,
        LOAD_THRESH_HI_ADDR, EEE_CTRL_ADDR, 9'h0fa};
    localparam logic [7:0] RV [8] = '{8'h27, 8'h03, 8'he8, 8'h03, 8'h40,
        8'h01, 8'h01, 8'h00};
    eee_lpi_entry_exit_control #(.WAIT_CYC(4), .REC_CYC(2)) DUT (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_txq_empty(txq_empty), .i_txq_push(txq_push),
        .i_buf_used(buf_used), .o_lpi_req(lpi_req), .o_tx_hold(tx_hold),
        .o_np_enable(np_enable), .o_lpi_exit_all(exit_all));
    queue_side_model partner (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_add(add), .i_bytes(bytes),
        .i_lpi_req(lpi_req), .i_tx_hold(tx_hold), .o_txq_empty(txq_empty),
        .o_txq_push(txq_push), .o_buf_used(buf_used));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic bus(input logic w, input logic rs, input logic [8:0] a,
                       input logic [7:0] d);
        i_wr <= w;
        i_rd <= rs;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic frame(input logic [2:0] m, input logic [15:0] n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        add <= m;
        bytes <= n;
        @(posedge i_mclk);
        add <= 3'b000;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        n_compared++;
        if (got !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe.
    always @(posedge i_mclk) begin
        if (rd_seen)
            chk(o_rdata, expq.pop_front());
        rd_seen = i_rd;
    end
    initial begin
        repeat (5000) @(posedge i_mclk);
        errors++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        chk({6'h00, np_enable}, 8'h03);
        for (int k = 0; k < 8; k++)
            rd(RA[k], RV[k]);
        wr(NP_CTRL_ADDR, 8'hfd);
        rd(NP_CTRL_ADDR, 8'hc1);
        wr(NP_CTRL_ADDR, 8'h02);
        wr(LOAD_THRESH_HI_ADDR, 8'hff);
        rd(LOAD_THRESH_HI_ADDR, 8'h01);
        idle(1);
        chk({6'h00, np_enable}, 8'h02);
        r = 8'h08 + 8'($random(seed) & 15);
        wr(RECOVERY_ADDR, r);
        rd(RECOVERY_ADDR, r);
        wr(WAIT_TIME_LO_ADDR, 8'h02);
        wr(WAIT_TIME_HI_ADDR, 8'h00);
        idle(30);
        rd(LPI_STATUS_ADDR, 8'h07);
        wr(WAIT_TIME_LO_ADDR, 8'h14);
        frame(3'b001, 16'h000a);
        idle(40);
        rd(LPI_STATUS_ADDR, 8'h06);
        idle(200);
        rd(LPI_STATUS_ADDR, 8'h07);
        wr(EEE_CTRL_ADDR, 8'h00);
        idle(4);
        rd(LPI_STATUS_ADDR, 8'h00);
        idle(100);
        rd(LPI_STATUS_ADDR, 8'h00);
        wr(EEE_CTRL_ADDR, 8'h01);
        idle(150);
        rd(LPI_STATUS_ADDR, 8'h07);
        wr(LOAD_THRESH_ADDR, 8'h01);
        frame(3'b010, 16'h0080);
        idle(6);
        rd(LPI_STATUS_ADDR, 8'h05);
        frame(3'b010, 16'h0001 + 16'($random(seed) & 63));
        idle(6);
        rd(LPI_STATUS_ADDR, 8'h80);
        chk({7'h00, exit_all}, 8'h01);
        chk({5'h00, lpi_req}, 8'h00);
        chk({5'h00, tx_hold}, 8'h07);
        wr(LOAD_THRESH_ADDR, 8'h40);
        idle(400);
        rd(LPI_STATUS_ADDR, 8'h07);
        idle(2);
        chk({5'h00, lpi_req}, 8'h07);
        chk({7'h00, exit_all}, 8'h00);
        close_out();
    end
endmodule
